/* hw/mcr_top.sv */
// Added by the designer: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module mcr_top #(
  parameter logic [17:0] TB_PERIOD_0 = mcr_pkg::TB_P0,
  parameter logic [17:0] TB_PERIOD_1 = mcr_pkg::TB_P1,
  parameter logic [17:0] TB_PERIOD_2 = mcr_pkg::TB_P2,
  parameter logic [17:0] TB_PERIOD_3 = mcr_pkg::TB_P3,
  parameter logic [12:0] TONE_HALF_HI  = mcr_pkg::TONE_H_HI,
  // Lower tones are whole multiples of the top tone's half period
  parameter logic [12:0] TONE_HALF_MID =
    13'(TONE_HALF_HI * (mcr_pkg::TONE_HZ_HI / mcr_pkg::TONE_HZ_MID)),
  parameter logic [12:0] TONE_HALF_LO  =
    13'(TONE_HALF_HI * (mcr_pkg::TONE_HZ_HI / mcr_pkg::TONE_HZ_LO))
) (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       halt_req_i,
  input  wire logic       wake_i,
  input  wire logic       global_mask_i,
  output logic            cpu_clk_en_o,
  output logic            clock_out_port_pin_o,
  output logic            clock_out_port_pin_oe_o,
  output logic            tone_port_pin_o,
  output logic            tone_port_pin_oe_o,
  output logic            tb_irq_o,
  output logic            evt_irq_o
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    mcr_pkg::mcr_mode_e mode;
    logic [7:0]         ccs;
    logic [1:0]         beep;
    logic [1:0]         evt;
    logic [1:0]         mask;
    logic [17:0]        tb_limit;
    logic [7:0]         rdata;
    logic               cpu_en;
    logic               clkout;
    logic               clkout_oe;
    logic               tone;
    logic               tone_oe;
    logic               tb_irq;
    logic               evt_irq;
  } mcr_top_s;

  mcr_top_s q;
  mcr_top_s d;

  logic       run;
  logic       slow;
  logic       tb_ie;
  logic [1:0] cpu_div;
  logic [1:0] tb_sel;

  mcr_tick_if #(.W(5))  cpu_tk ();
  mcr_tick_if #(.W(18)) tb_tk ();
  mcr_tick_if #(.W(13)) tone_tk ();

  assign run     = (q.mode == mcr_pkg::MCR_RUN);
  assign slow    = q.ccs[mcr_pkg::BIT_SLOW];
  assign tb_ie   = q.ccs[mcr_pkg::BIT_IE];
  assign cpu_div = q.ccs[mcr_pkg::CPUDIV_LSB +: 2];
  assign tb_sel  = q.ccs[mcr_pkg::TB_LSB +: 2];

  // ****************************************
  // Lookup of periods
  // ****************************************
  function automatic logic [17:0] tb_period(input logic [1:0] sel);
    case (sel)
      2'h0: tb_period = TB_PERIOD_0;
      2'h1: tb_period = TB_PERIOD_1;
      2'h2: tb_period = TB_PERIOD_2;
      2'h3: tb_period = TB_PERIOD_3;
      default: tb_period = TB_PERIOD_0;
    endcase
  endfunction

  function automatic logic [12:0] tone_half(input logic [1:0] sel);
    case (sel)
      2'h1: tone_half = TONE_HALF_HI;
      2'h2: tone_half = TONE_HALF_MID;
      2'h3: tone_half = TONE_HALF_LO;
      default: tone_half = TONE_HALF_HI;
    endcase
  endfunction

  // ****************************************
  // Dividers
  // ****************************************
  // CPU prescaler only counts in slow mode while running
  assign cpu_tk.run   = run && slow;
  assign cpu_tk.limit = mcr_pkg::CPU_DIV_BASE << cpu_div;
  // Time base runs in run and ACTIVE-HALT, stopped and cleared to zero in full HALT
  assign tb_tk.run    = (q.mode != mcr_pkg::MCR_HALT);
  assign tb_tk.limit  = q.tb_limit;
  // Beeper stays alive in ACTIVE-HALT
  assign tone_tk.run   = (q.beep != 2'h0) && (q.mode != mcr_pkg::MCR_HALT);
  assign tone_tk.limit = tone_half(q.beep);

  mcr_divider #(.W(5)) u_cpu_div (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tk      (cpu_tk)
  );

  mcr_divider #(.W(18)) u_tb_div (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tk      (tb_tk)
  );

  mcr_tone #(.W(13)) u_tone (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tk      (tone_tk)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    d       = q;
    d.rdata = 8'h00;

    // Register writes; writes are ignored outside run mode
    if (run && wr_i)
    begin
      case (addr_i)
        mcr_pkg::OFS_CCS:  d.ccs = {wdata_i[7:1], q.ccs[mcr_pkg::BIT_FLAG]};
        mcr_pkg::OFS_BEEP: d.beep = wdata_i[1:0];
        mcr_pkg::OFS_EVT:  d.evt = q.evt & ~wdata_i[1:0];
        mcr_pkg::OFS_MASK: d.mask = wdata_i[1:0];
        default: d.mask = q.mask;
      endcase
    end

    // Read data, valid only in the cycle after the strobe
    if (rd_i)
    begin
      case (addr_i)
        mcr_pkg::OFS_CCS:  d.rdata = q.ccs;
        mcr_pkg::OFS_BEEP: d.rdata = {6'h00, q.beep};
        mcr_pkg::OFS_EVT:  d.rdata = {6'h00, q.evt};
        mcr_pkg::OFS_MASK: d.rdata = {6'h00, q.mask};
        default: d.rdata = 8'h00;
      endcase
    end

    // A read of the CCS register in run mode clears the flag; a write leaves it alone
    if (run && rd_i && (addr_i == mcr_pkg::OFS_CCS))
      d.ccs[mcr_pkg::BIT_FLAG] = 1'b0;

    // Period end: flag set wins over a clearing read, new period latched
    if (tb_tk.tick)
    begin
      d.ccs[mcr_pkg::BIT_FLAG] = 1'b1;
      d.evt[mcr_pkg::EVT_PERIOD] = 1'b1;
      d.tb_limit = tb_period(tb_sel);
    end

    // Power mode sequencing; WAIT is not seen here and changes nothing
    case (q.mode)
      mcr_pkg::MCR_RUN:
      begin
        if (halt_req_i)
          d.mode = tb_ie ? mcr_pkg::MCR_ACT_HALT : mcr_pkg::MCR_HALT;
      end
      mcr_pkg::MCR_ACT_HALT:
      begin
        if ((tb_tk.tick && tb_ie) || wake_i)
        begin
          d.mode = mcr_pkg::MCR_RUN;
          d.evt[mcr_pkg::EVT_WAKE] = 1'b1;
        end
      end
      mcr_pkg::MCR_HALT:
      begin
        if (wake_i)
          d.mode = mcr_pkg::MCR_RUN;
      end
      default: d.mode = mcr_pkg::MCR_RUN;
    endcase

    // CPU clock enable while running: every cycle in normal mode, divided in slow mode; off in both halt modes
    d.cpu_en = run && (!slow || cpu_tk.tick);

    // Clock-out toggles every cycle in normal mode, follows the CPU rate in slow mode; parked low while not selected or not running
    if (!run || !q.ccs[mcr_pkg::BIT_CLKOUT])
      d.clkout = 1'b0;
    else if (!slow)
      d.clkout = ~q.clkout;
    else
      d.clkout = cpu_tk.wave;
    d.clkout_oe = q.ccs[mcr_pkg::BIT_CLKOUT]
                  && (q.mode != mcr_pkg::MCR_ACT_HALT);

    d.tone    = tone_tk.wave;
    d.tone_oe = (q.beep != 2'h0);

    // Interrupt request also serves as the WAIT exit
    d.tb_irq  = q.ccs[mcr_pkg::BIT_FLAG] && tb_ie && !global_mask_i;
    d.evt_irq = |(q.evt & q.mask);
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      q          <= '0;
      q.ccs      <= mcr_pkg::RST_CCS;
      q.beep     <= mcr_pkg::RST_BEEP;
      q.evt      <= mcr_pkg::RST_EVT;
      q.mask     <= mcr_pkg::RST_MASK;
      q.tb_limit <= TB_PERIOD_0;
    end
    else
      q <= d;
  end

  assign rdata_o                 = q.rdata;
  assign cpu_clk_en_o            = q.cpu_en;
  assign clock_out_port_pin_o    = q.clkout;
  assign clock_out_port_pin_oe_o = q.clkout_oe;
  assign tone_port_pin_o         = q.tone;
  assign tone_port_pin_oe_o      = q.tone_oe;
  assign tb_irq_o                = q.tb_irq;
  assign evt_irq_o               = q.evt_irq;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_normal_full_rate: assert property (
    run && !slow |=> cpu_clk_en_o)
    else $error("CPU enable missing in normal mode");

  a_slow_half_rate: assert property (
    (run && slow && cpu_div == 2'h0) [*4] |-> (cpu_clk_en_o != $past(cpu_clk_en_o)))
    else $error("Divide by two enable does not alternate");

  a_slow_sixteen: assert property (
    (run && slow && cpu_div == 2'h3) [*3] ##0 cpu_clk_en_o
    ##1 (run && slow && cpu_div == 2'h3) [*8] |-> !cpu_clk_en_o)
    else $error("Divide by sixteen enable too close");

  a_clkout_select: assert property (
    !q.ccs[mcr_pkg::BIT_CLKOUT] |=> !clock_out_port_pin_oe_o)
    else $error("Clock-out driven while not selected");

  a_clkout_quiet: assert property (
    !q.ccs[mcr_pkg::BIT_CLKOUT] |=> !clock_out_port_pin_o)
    else $error("Clock-out pin toggles while not selected");

  a_clkout_suspend: assert property (
    q.mode == mcr_pkg::MCR_ACT_HALT |=> !clock_out_port_pin_oe_o)
    else $error("Clock-out active in ACTIVE-HALT");

  a_period_hold: assert property (
    !tb_tk.tick |=> $stable(q.tb_limit))
    else $error("Time-base period changed mid-period");

  a_flag_set: assert property (
    tb_tk.tick |=> q.ccs[mcr_pkg::BIT_FLAG])
    else $error("Time-base flag not set at period end");

  a_flag_read_clear: assert property (
    run && rd_i && addr_i == mcr_pkg::OFS_CCS && !tb_tk.tick
    |=> !q.ccs[mcr_pkg::BIT_FLAG])
    else $error("Flag not cleared by read");

  a_flag_sticky: assert property (
    q.ccs[mcr_pkg::BIT_FLAG] && !(rd_i && addr_i == mcr_pkg::OFS_CCS)
    |=> q.ccs[mcr_pkg::BIT_FLAG])
    else $error("Flag lost without a read");

  a_irq_gate: assert property (
    tb_irq_o |-> $past(q.ccs[mcr_pkg::BIT_FLAG] && tb_ie && !global_mask_i))
    else $error("Interrupt raised without enable or with mask");

  a_halt_entry: assert property (
    run && halt_req_i |=> q.mode == ($past(tb_ie) ? mcr_pkg::MCR_ACT_HALT : mcr_pkg::MCR_HALT))
    else $error("Wrong halt mode entered");

  a_active_wake: assert property (
    q.mode == mcr_pkg::MCR_ACT_HALT && tb_tk.tick && tb_ie |=> run ##1 cpu_clk_en_o || slow)
    else $error("No wake from ACTIVE-HALT on period end");

  a_halt_freeze: assert property (
    q.mode == mcr_pkg::MCR_HALT && !wake_i |=> q.mode == mcr_pkg::MCR_HALT && !tb_tk.tick)
    else $error("Full HALT left or counting without wake");

  a_beep_off: assert property (
    (q.beep == 2'h0) [*3] |-> !tone_port_pin_o && !tone_port_pin_oe_o)
    else $error("Tone pin active while beeper off");

  c_active_halt: cover property (run && halt_req_i && tb_ie ##1 q.mode == mcr_pkg::MCR_ACT_HALT);
  c_tb_wake: cover property (q.mode == mcr_pkg::MCR_ACT_HALT && tb_tk.tick ##1 run);
  c_slow_mode: cover property (run && slow && cpu_div == 2'h3 && cpu_clk_en_o);
  c_tone_edge: cover property ($rose(tone_port_pin_o));
  c_full_halt: cover property (run && halt_req_i && !tb_ie ##1 q.mode == mcr_pkg::MCR_HALT);
endmodule
`default_nettype wire

/* inc/mcr_pkg.sv */
`default_nettype none
package mcr_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CCS  = 8'h2c;
  localparam logic [7:0] OFS_BEEP = 8'h2d;
  localparam logic [7:0] OFS_EVT  = 8'h2e;
  localparam logic [7:0] OFS_MASK = 8'h2f;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_CLKOUT = 7;
  localparam int CPUDIV_LSB = 5;
  localparam int BIT_SLOW   = 4;
  localparam int TB_LSB     = 2;
  localparam int BIT_IE     = 1;
  localparam int BIT_FLAG   = 0;
  localparam int EVT_PERIOD = 0;
  localparam int EVT_WAKE   = 1;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_CCS  = 8'h00;
  localparam logic [1:0] RST_BEEP = 2'h0;
  localparam logic [1:0] RST_EVT  = 2'h0;
  localparam logic [1:0] RST_MASK = 2'h0;
  // ****************************************
  // Timing counts in oscillator cycles, rates in Hz
  // ****************************************
  localparam logic [4:0]  CPU_DIV_BASE = 5'h02;
  localparam logic [17:0] TB_P0        = 18'h0_3e80;
  localparam logic [17:0] TB_P1        = 18'h0_7d00;
  localparam logic [17:0] TB_P2        = 18'h1_3880;
  localparam logic [17:0] TB_P3        = 18'h3_0d40;
  localparam int unsigned BEEP_REF_HZ  = 32'h007a_1200;
  localparam int unsigned TONE_HZ_HI   = 32'h0000_07d0;
  localparam int unsigned TONE_HZ_MID  = 32'h0000_03e8;
  localparam int unsigned TONE_HZ_LO   = 32'h0000_01f4;
  localparam logic [12:0] TONE_H_HI    = 13'(BEEP_REF_HZ / (2 * TONE_HZ_HI));
  localparam logic [12:0] TONE_H_MID   = 13'(BEEP_REF_HZ / (2 * TONE_HZ_MID));
  localparam logic [12:0] TONE_H_LO    = 13'(BEEP_REF_HZ / (2 * TONE_HZ_LO));
  // ****************************************
  // Power modes
  // ****************************************
  typedef enum logic [1:0] {
    MCR_RUN      = 2'b00,
    MCR_ACT_HALT = 2'b01,
    MCR_HALT     = 2'b10
  } mcr_mode_e;
endpackage
`default_nettype wire

/* inc/mcr_tick_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface mcr_tick_if #(
  parameter int W = 18
);
  logic         run;
  logic [W-1:0] limit;
  logic         tick;
  logic         wave;
  modport ctl (output run, output limit, input tick, input wave);
  modport div (input run, input limit, output tick, output wave);
  modport sq  (input run, input limit, output wave);
endinterface
`default_nettype wire

/* hw/mcr_divider.sv */
`timescale 1ns/10ps
`default_nettype none
module mcr_divider #(
  parameter int W = 18
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  mcr_tick_if.div   tk
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
    logic         wave;
  } mcr_div_s;

  mcr_div_s q;
  mcr_div_s d;

  // Counts limit cycles, pulses tick on wrap and restarts by itself
  always_comb
  begin
    d      = q;
    d.tick = 1'b0;
    if (!tk.run)
      d.cnt = '0;
    else if (q.cnt == tk.limit - W'(1))
    begin
      d.cnt  = '0;
      d.tick = 1'b1;
    end
    else
      d.cnt = q.cnt + W'(1);
    d.wave = tk.run && (d.cnt < (tk.limit >> 1));
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      q <= '0;
    else
      q <= d;
  end

  assign tk.tick = q.tick;
  assign tk.wave = q.wave;
endmodule
`default_nettype wire

/* hw/mcr_tone.sv */
`timescale 1ns/10ps
`default_nettype none
module mcr_tone #(
  parameter int W = 13
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  mcr_tick_if.sq    tk
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         wave;
  } mcr_tone_s;

  mcr_tone_s q;
  mcr_tone_s d;

  // Square wave, toggles every limit cycles; parked low while off
  always_comb
  begin
    d = q;
    if (!tk.run)
    begin
      d.cnt  = '0;
      d.wave = 1'b0;
    end
    else if (q.cnt == tk.limit - W'(1))
    begin
      d.cnt  = '0;
      d.wave = ~q.wave;
    end
    else
      d.cnt = q.cnt + W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      q <= '0;
    else
      q <= d;
  end

  assign tk.wave = q.wave;
endmodule
`default_nettype wire

/* dv/mcr_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mcr_cpu_model (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic cpu_clk_en_i,
  input  wire logic sleep_i,
  input  wire logic nudge_i,
  input  wire logic mask_i,
  output logic      halt_req_o,
  output logic      wake_o,
  output logic      global_mask_o
);
  // ****************************************
  // CPU side: halt, external wake, mask
  // ****************************************
  // A halt instruction retires only on a cycle where the CPU clock runs
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      halt_req_o    <= 1'b0;
      wake_o        <= 1'b0;
      global_mask_o <= 1'b0;
    end
    else
    begin
      halt_req_o    <= sleep_i & cpu_clk_en_i;
      wake_o        <= nudge_i;
      global_mask_o <= mask_i;
    end
  end
endmodule
`default_nettype wire

/* dv/main_clock_rtc_beeper_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module main_clock_rtc_beeper_bench;
  logic       clk_i;
  logic       rst_b_i;
  logic       wr_i;
  logic       rd_i;
  logic       slp;
  logic       nudge;
  logic       gm;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic [7:0] rdata_o;
  logic       halt_req;
  logic       wake;
  logic       gmask;
  logic       cpu_en;
  logic       co_pin;
  logic       co_oe;
  logic       tone;
  logic       tone_oe;
  logic       tb_irq;
  logic       evt_irq;
  logic       rd_q = 1'b0;
  logic       irq_q = 1'b0;
  logic [7:0] exp_rd [$];
  int         exp_gap [$];
  int         mismatches;
  int         total_checks;
  int         cyc;
  int         last_rise;
  int         f;
  int         old;

  mcr_top #(
    .TB_PERIOD_0   (18'h0_0010),
    .TB_PERIOD_1   (18'h0_0020),
    .TB_PERIOD_2   (18'h0_0050),
    .TB_PERIOD_3   (18'h0_00c8),
    .TONE_HALF_HI  (13'h0004)
  ) DUT (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .halt_req_i(halt_req),
    .wake_i(wake), .global_mask_i(gmask), .cpu_clk_en_o(cpu_en),
    .clock_out_port_pin_o(co_pin), .clock_out_port_pin_oe_o(co_oe),
    .tone_port_pin_o(tone), .tone_port_pin_oe_o(tone_oe),
    .tb_irq_o(tb_irq), .evt_irq_o(evt_irq)
  );

  mcr_cpu_model cpu (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .cpu_clk_en_i(cpu_en), .sleep_i(slp),
    .nudge_i(nudge), .mask_i(gm), .halt_req_o(halt_req), .wake_o(wake),
    .global_mask_o(gmask)
  );

  // ****************************************
  // Helpers
  // ****************************************
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_rd.push_back(e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask

  task pulse(input int w);
    @(posedge clk_i);
    if (w == 0) slp <= 1'b1;
    else nudge <= 1'b1;
    @(posedge clk_i);
    slp   <= 1'b0;
    nudge <= 1'b0;
  endtask

  function logic pick(input int s);
    return (s == 0) ? cpu_en : (s == 1) ? co_pin : tone;
  endfunction

  // Counts enable cycles (sel 0) or level changes of a pin (sel 1, 2)
  task cnt_tog(input int s, input int n, input string nm, input int e);
    logic p;
    int   c;
    c = 0;
    p = pick(s);
    repeat (n)
    begin
      @(posedge clk_i);
      c = c + ((s == 0) ? int'(pick(s)) : int'(pick(s) != p));
      p = pick(s);
    end
    chk(nm, e, c);
  endtask

  // Waits for the time-base request, then clears the flag with one read and checks it is clear with a second
  task wait_irq(input logic [7:0] v);
    int k;
    k = 0;
    while (tb_irq !== 1'b1 && k < 400)
    begin
      @(posedge clk_i);
      k++;
    end
    chk("irq wait", 1, tb_irq);
    rd(8'h2c, v | 8'h01);
    rd(8'h2c, v);
  endtask

  function int per(input int t);
    return (t == 0) ? 16 : (t == 1) ? 32 : (t == 2) ? 80 : 200;
  endfunction

  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge clk_i)
  begin
    if (rd_q)
      chk("rdata", (exp_rd.size() > 0) ? exp_rd.pop_front() : 8'hxx, rdata_o);
    rd_q <= rd_i;
    if (tb_irq === 1'b1 && irq_q !== 1'b1)
    begin
      if (exp_gap.size() > 0)
        chk("period", exp_gap.pop_front(), cyc - last_rise);
      last_rise = cyc;
    end
    irq_q <= tb_irq;
    cyc++;
    if (cyc > 20000)
    begin
      mismatches++;
      summarize();
    end
  end

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    {rst_b_i, wr_i, rd_i, slp, nudge, gm} = '0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    {mismatches, total_checks, cyc, last_rise} = '0;
    void'($urandom(83602));
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(8'h2c, 8'h00);
    rd(8'h2d, 8'h00);
    rd(8'h2e, 8'h00);
    rd(8'h2f, 8'h00);
    repeat (4)
    begin
      addr_i <= 8'h30 + 8'($urandom_range(0, 207));
      @(posedge clk_i);
      wr(addr_i, 8'($urandom));
      rd(addr_i, 8'h00);
    end
    $display("reset and map test finished");
    cnt_tog(0, 32, "normal enables", 32);
    for (int cp = 0; cp < 4; cp++)
    begin
      wr(8'h2c, 8'(cp << 5) | 8'h10);
      repeat (20) @(posedge clk_i);
      cnt_tog(0, 64, "slow enables", 64 >> (cp + 1));
    end
    wr(8'h2c, 8'h80);
    repeat (4) @(posedge clk_i);
    chk("clock out oe", 1, co_oe);
    cnt_tog(1, 16, "clock out", 16);
    wr(8'h2c, 8'h00);
    repeat (4) @(posedge clk_i);
    chk("clock out oe", 0, co_oe);
    chk("clock out pin", 0, co_pin);
    $display("prescaler test finished");
    for (int bc = 1; bc < 4; bc++)
    begin
      wr(8'h2d, 8'(bc));
      rd(8'h2d, 8'(bc));
      repeat (4) @(posedge clk_i);
      chk("tone oe", 1, tone_oe);
      cnt_tog(2, 64, "tone", 16 >> (bc - 1));
    end
    wr(8'h2d, 8'h00);
    repeat (4) @(posedge clk_i);
    chk("tone oe", 0, tone_oe);
    chk("tone pin", 0, tone);
    $display("beep test finished");
    // Mid-run reset also pins the time-base phase for the period checks
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rd(8'h2c, 8'h00);
    wr(8'h2c, 8'h02);
    wait_irq(8'h02);
    old = 0;
    for (int i = 0; i < 4; i++)
    begin
      f = (i + 1) % 4;
      wr(8'h2c, 8'(f << 2) | 8'h02);
      exp_gap.push_back(per(old));
      exp_gap.push_back(per(f));
      wait_irq(8'(f << 2) | 8'h02);
      wait_irq(8'(f << 2) | 8'h02);
      old = f;
    end
    $display("time base test finished");
    gm <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk("irq masked", 0, tb_irq);
    rd(8'h2c, 8'h03);
    gm <= 1'b0;
    wait_irq(8'h02);
    wr(8'h2c, 8'h00);
    repeat (40) @(posedge clk_i);
    chk("irq disabled", 0, tb_irq);
    rd(8'h2c, 8'h01);
    wr(8'h2c, 8'h0e);
    wait_irq(8'h0e);
    wait_irq(8'h0e);
    rd(8'h2e, 8'h01);
    chk("event irq", 0, evt_irq);
    wr(8'h2f, 8'h01);
    rd(8'h2f, 8'h01);
    chk("event irq", 1, evt_irq);
    wr(8'h2e, 8'h01);
    rd(8'h2e, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("event irq", 0, evt_irq);
    $display("interrupt test finished");
    wr(8'h2c, 8'h8e);
    wr(8'h2d, 8'h01);
    wr(8'h2f, 8'h02);
    wait_irq(8'h8e);
    pulse(0);
    repeat (4) @(posedge clk_i);
    chk("cpu enable", 0, cpu_en);
    chk("clock out oe", 0, co_oe);
    cnt_tog(2, 32, "tone in halt", 8);
    wr(8'h2c, 8'h00);
    f = 0;
    while (cpu_en !== 1'b1 && f < 250)
    begin
      @(posedge clk_i);
      f++;
    end
    chk("cpu enable", 1, cpu_en);
    repeat (2) @(posedge clk_i);
    chk("event irq", 1, evt_irq);
    rd(8'h2c, 8'h8f);
    rd(8'h2e, 8'h03);
    wr(8'h2c, 8'h0c);
    wr(8'h2e, 8'h03);
    wr(8'h2d, 8'h00);
    pulse(0);
    repeat (4) @(posedge clk_i);
    chk("cpu enable", 0, cpu_en);
    repeat (450) @(posedge clk_i);
    chk("cpu enable", 0, cpu_en);
    pulse(1);
    repeat (5) @(posedge clk_i);
    chk("cpu enable", 1, cpu_en);
    $display("halt test finished");
    repeat (4) @(posedge clk_i);
    summarize();
  end
endmodule
`default_nettype wire
